// ---- src/mstc_pkg.sv ----
// Purpose: constants for the monitor, signaling and timer control bank
// Assumes: 4-bit register address, 8-bit data, 250 MHz core clock
// Notes: register offsets are shared by read and write at the same index
package mstc_pkg;
	localparam logic [3:0] MSTC_ADDR_ACTIVE = 4'ha;
	localparam logic [3:0] MSTC_ADDR_MFIFO = 4'hb;
	localparam logic [3:0] MSTC_ADDR_SIGTIM = 4'hc;
	localparam logic [3:0] MSTC_ADDR_STATCMD = 4'hd;
	localparam logic [7:0] MSTC_RST_ACTIVE = 8'h00;
	localparam logic [7:0] MSTC_RST_TIMER = 8'h00;
	localparam logic [7:0] MSTC_RST_BWCODE = 8'h01;
	// command bit positions
	localparam int MSTC_CMD_GO = 6;
	localparam int MSTC_CMD_IRQEN = 5;
	localparam int MSTC_CMD_SFLUSH = 4;
	localparam int MSTC_CMD_XFER_HI = 3;
	localparam int MSTC_CMD_XFER_LO = 2;
	localparam int MSTC_CMD_SRCH = 1;
	localparam int MSTC_CMD_MFLUSH = 0;
	// status bit positions
	localparam int MSTC_STAT_BUSY = 7;
	localparam int MSTC_STAT_TIMER = 6;
	localparam int MSTC_STAT_LOCK = 5;
	localparam int MSTC_STAT_XACT = 4;
	localparam int MSTC_STAT_ABORT = 3;
	localparam int MSTC_STAT_ACC = 2;
	localparam int MSTC_STAT_DIR = 1;
	localparam int MSTC_STAT_EMPTY = 0;
	localparam int MSTC_SIG_DEPTH = 9;
	localparam int MSTC_MON_DEPTH = 16;
	// timing
	localparam int MSTC_CLK_MHZ = 250;
	localparam int MSTC_TICK_US = 250;
	localparam int MSTC_LOOK_FIX_US = 125;
	localparam int MSTC_TICK_CYC = MSTC_TICK_US * MSTC_CLK_MHZ;
	localparam int MSTC_LOOK_FIX_CYC = MSTC_LOOK_FIX_US * MSTC_CLK_MHZ;
	localparam int MSTC_FLUSH_MAX = 2;
	localparam logic [7:0] MSTC_SLOT_LAST = 8'h3f;
	localparam logic [2:0] MSTC_BW_FULL = 3'h1;
endpackage : mstc_pkg

// ---- src/mstc_fifo.sv ----
// Purpose: flop-based fifo with valid/ready on both sides
// Assumes: synchronous flush, single clock
// Notes: full and empty are exact, never speculative
`timescale 1ns/100ps
`default_nettype none
module mstc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [AW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
	logic [$clog2(DEPTH+1)-1:0] cnt_r, cnt_nxt;
	logic push, pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign in_ready = (cnt_r != ($clog2(DEPTH+1))'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_r];
	assign level = cnt_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		mem_nxt = mem_r;
		rd_nxt = rd_r;
		wr_nxt = wr_r;
		cnt_nxt = cnt_r;
		if (flush) begin
			rd_nxt = '0;
			wr_nxt = '0;
			cnt_nxt = '0;
		end else begin
			if (push) begin
				mem_nxt[wr_r] = in_data;
				wr_nxt = bump(wr_r);
			end
			if (pop)
				rd_nxt = bump(rd_r);
			if (push && !pop)
				cnt_nxt = cnt_r + 1'b1;
			else if (pop && !push)
				cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= '0;
			rd_r <= '0;
			wr_r <= '0;
			cnt_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule : mstc_fifo
`default_nettype wire

// ---- src/mstc_ctrl.sv ----
// Purpose: processor register bank for monitor channel, signaling fifo and timer
// Assumes: host strobes are synchronous to core_clk; line side abstracted to strobes
// Notes: pin-level line inputs pass a two-stage synchroniser
`timescale 1ns/100ps
`default_nettype none
module mstc_ctrl
	import mstc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic operation_mode_bit0,
	input wire logic handshake_protocol_select,
	input wire logic memory_op_busy_in,
	input wire logic frame_match_in,
	input wire logic [2:0] slot_bandwidth_code,
	input wire logic [7:0] slot_byte_in,
	output logic [7:0] slot_bits_out,
	output logic slot_code_illegal,
	input wire logic sig_change_valid,
	input wire logic [6:0] sig_change_slot,
	input wire logic sig_change_is_line,
	input wire logic [5:0] scan_slot,
	input wire logic monitor_handover_bit,
	input wire logic mon_line_ready,
	output logic mon_tx_valid,
	output logic [7:0] mon_tx_byte,
	output logic [7:0] mon_subscriber,
	output logic [1:0] mon_xfer_cmd,
	output logic mon_xfer_hs,
	input wire logic mon_rx_valid,
	input wire logic [7:0] mon_rx_byte,
	input wire logic mon_xfer_done,
	input wire logic mon_remote_abort,
	output logic timer_event,
	output logic last_look_tick
);
	// ---------------------------------------------
	// host strobes and synchronised line levels
	// ---------------------------------------------
	logic [1:0] hs_sync_r, hs_sync_nxt;
	logic [1:0] lock_sync_r, lock_sync_nxt;
	logic wr_cmd, wr_tim, wr_sub, wr_mon, rd_sig, rd_mon;
	logic [7:0] cmd;

	assign wr_cmd = reg_wr && reg_addr == MSTC_ADDR_STATCMD;
	assign wr_tim = reg_wr && reg_addr == MSTC_ADDR_SIGTIM;
	assign wr_sub = reg_wr && reg_addr == MSTC_ADDR_ACTIVE;
	assign wr_mon = reg_wr && reg_addr == MSTC_ADDR_MFIFO;
	assign rd_sig = reg_rd && reg_addr == MSTC_ADDR_SIGTIM;
	assign rd_mon = reg_rd && reg_addr == MSTC_ADDR_MFIFO;
	// the top bit is ignored, so a stray 1 there triggers nothing
	assign cmd = wr_cmd ? {1'b0, reg_wdata[6:0]} : 8'h00;

	always_comb begin
		hs_sync_nxt = {hs_sync_r[0], monitor_handover_bit};
		lock_sync_nxt = {lock_sync_r[0], frame_match_in};
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hs_sync_r <= 2'b11;
			lock_sync_r <= 2'b00;
		end else begin
			hs_sync_r <= hs_sync_nxt;
			lock_sync_r <= lock_sync_nxt;
		end
	end

	// ---------------------------------------------
	// synchronous transfer bit selection
	// ---------------------------------------------
	always_comb begin
		slot_code_illegal = 1'b0;
		unique case (slot_bandwidth_code)
			3'h1: slot_bits_out = slot_byte_in;
			3'h2: slot_bits_out = {4'h0, slot_byte_in[3:0]};
			3'h3: slot_bits_out = {4'h0, slot_byte_in[7:4]};
			3'h4: slot_bits_out = {6'h00, slot_byte_in[1:0]};
			3'h5: slot_bits_out = {6'h00, slot_byte_in[3:2]};
			3'h6: slot_bits_out = {6'h00, slot_byte_in[5:4]};
			3'h7: slot_bits_out = {6'h00, slot_byte_in[7:6]};
			default: begin
				slot_bits_out = 8'h00;
				slot_code_illegal = 1'b1;
			end
		endcase
	end

	// ---------------------------------------------
	// timer and last-look
	// ---------------------------------------------
	logic [7:0] tim_r, tim_nxt;
	logic run_r, run_nxt, irqen_r, irqen_nxt;
	logic [15:0] pre_r, pre_nxt, look_r, look_nxt;
	logic [6:0] cnt_r, cnt_nxt;
	logic tev_r, tev_nxt, llk_r, llk_nxt, tick;

	assign tick = run_r && pre_r == 16'(MSTC_TICK_CYC - 1);

	always_comb begin
		tim_nxt = wr_tim ? reg_wdata : tim_r;
		run_nxt = run_r;
		irqen_nxt = irqen_r;
		pre_nxt = run_r ? (tick ? 16'h0000 : pre_r + 16'h0001) : 16'h0000;
		cnt_nxt = cnt_r;
		tev_nxt = 1'b0;
		if (tick) begin
			cnt_nxt = (cnt_r == tim_r[6:0]) ? 7'h00 : cnt_r + 7'h01;
			tev_nxt = (cnt_r == tim_r[6:0]) && irqen_r;
		end
		if (cmd[MSTC_CMD_GO]) begin
			run_nxt = 1'b1;
			irqen_nxt = cmd[MSTC_CMD_IRQEN];
			pre_nxt = 16'h0000;
			cnt_nxt = 7'h00;
		end
		if (wr_tim || !operation_mode_bit0) begin
			run_nxt = 1'b0;
			pre_nxt = 16'h0000;
			cnt_nxt = 7'h00;
		end
		llk_nxt = 1'b0;
		look_nxt = look_r + 16'h0001;
		if (tim_r[7]) begin
			if (look_r >= 16'(MSTC_LOOK_FIX_CYC - 1)) begin
				look_nxt = 16'h0000;
				llk_nxt = 1'b1;
			end
		end else if (tick && cnt_r == tim_r[6:0]) begin
			look_nxt = 16'h0000;
			llk_nxt = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tim_r <= MSTC_RST_TIMER;
			run_r <= 1'b0;
			irqen_r <= 1'b0;
			pre_r <= 16'h0000;
			look_r <= 16'h0000;
			cnt_r <= 7'h00;
			tev_r <= 1'b0;
			llk_r <= 1'b0;
		end else begin
			tim_r <= tim_nxt;
			run_r <= run_nxt;
			irqen_r <= irqen_nxt;
			pre_r <= pre_nxt;
			look_r <= look_nxt;
			cnt_r <= cnt_nxt;
			tev_r <= tev_nxt;
			llk_r <= llk_nxt;
		end
	end
	assign timer_event = tev_r;
	assign last_look_tick = llk_r;

	// ---------------------------------------------
	// signaling change fifo
	// ---------------------------------------------
	logic [6:0] sig_addr;
	logic sig_ovalid, sig_flush_r, sig_flush_nxt;
	logic [6:0] sig_odata;
	// line-state changes land on the odd stable-value address
	assign sig_addr = {sig_change_slot[6:1], sig_change_is_line};
	assign sig_flush_nxt = cmd[MSTC_CMD_SFLUSH];

	// flush lands one edge after the write, inside the 2 clock budget
	mstc_fifo #(.WIDTH(7), .DEPTH(MSTC_SIG_DEPTH)) u_sig_fifo (
		.core_clk(core_clk),
		.rstn(rstn),
		.flush(sig_flush_r),
		.in_valid(sig_change_valid),
		.in_ready(),
		.in_data(sig_addr),
		.out_valid(sig_ovalid),
		.out_ready(rd_sig),
		.out_data(sig_odata),
		.level()
	);

	// ---------------------------------------------
	// monitor channel handler
	// ---------------------------------------------
	typedef enum logic [1:0] {MSTC_IDLE, MSTC_XFER, MSTC_SEARCH} mstc_state_e;
	mstc_state_e state_r, state_nxt;
	logic [7:0] sub_r, sub_nxt, act_r, act_nxt;
	logic [1:0] xcmd_r, xcmd_nxt;
	logic srch_r, srch_nxt, abort_r, abort_nxt, dir_r, dir_nxt;
	logic mflush_r, mflush_nxt;
	logic mon_in_valid, mon_out_valid, mon_out_ready;
	logic [7:0] mon_in_data, mon_out_data;
	logic [4:0] mon_level;

	// host fills while writable, line fills while receiving
	assign mon_in_valid = dir_r ? mon_rx_valid : wr_mon;
	assign mon_in_data = dir_r ? mon_rx_byte : reg_wdata;
	assign mon_out_ready = (state_r == MSTC_XFER && !dir_r) ? mon_line_ready : rd_mon;

	mstc_fifo #(.WIDTH(8), .DEPTH(MSTC_MON_DEPTH)) u_mon_fifo (
		.core_clk(core_clk),
		.rstn(rstn),
		.flush(mflush_r),
		.in_valid(mon_in_valid),
		.in_ready(),
		.in_data(mon_in_data),
		.out_valid(mon_out_valid),
		.out_ready(mon_out_ready),
		.out_data(mon_out_data),
		.level(mon_level)
	);

	assign mon_tx_valid = state_r == MSTC_XFER && !dir_r && mon_out_valid;
	assign mon_tx_byte = mon_out_data;
	assign mon_subscriber = sub_r;
	assign mon_xfer_cmd = xcmd_r;
	assign mon_xfer_hs = handshake_protocol_select;

	always_comb begin
		state_nxt = state_r;
		sub_nxt = wr_sub ? reg_wdata : sub_r;
		act_nxt = act_r;
		xcmd_nxt = xcmd_r;
		srch_nxt = srch_r;
		abort_nxt = abort_r;
		dir_nxt = dir_r;
		mflush_nxt = cmd[MSTC_CMD_MFLUSH];
		unique case (state_r)
			MSTC_IDLE: begin
				// once the host has drained received bytes the fifo takes writes again
				if (dir_r && !mon_out_valid)
					dir_nxt = 1'b0;
				if (cmd[MSTC_CMD_XFER_HI:MSTC_CMD_XFER_LO] != 2'b00) begin
					state_nxt = MSTC_XFER;
					xcmd_nxt = cmd[MSTC_CMD_XFER_HI:MSTC_CMD_XFER_LO];
					abort_nxt = 1'b0;
				end else if (cmd[MSTC_CMD_SRCH]) begin
					state_nxt = MSTC_SEARCH;
					srch_nxt = 1'b1;
				end
			end
			MSTC_XFER: begin
				if (mon_remote_abort && handshake_protocol_select)
					abort_nxt = 1'b1;
				if (xcmd_r[1] && !mon_out_valid)
					dir_nxt = 1'b1;
				if (mon_xfer_done || mon_remote_abort) begin
					state_nxt = MSTC_IDLE;
					xcmd_nxt = 2'b00;
				end
			end
			MSTC_SEARCH: begin
				if (!hs_sync_r[1]) begin
					act_nxt = {2'b00, scan_slot};
					srch_nxt = 1'b0;
					state_nxt = MSTC_IDLE;
				end else if (!operation_mode_bit0) begin
					srch_nxt = 1'b0;
					state_nxt = MSTC_IDLE;
				end
			end
			default: state_nxt = MSTC_IDLE;
		endcase
		if (mflush_r) begin
			dir_nxt = 1'b0;
			if (state_r == MSTC_XFER) begin
				state_nxt = MSTC_IDLE;
				xcmd_nxt = 2'b00;
				abort_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= MSTC_IDLE;
			sub_r <= 8'h00;
			act_r <= MSTC_RST_ACTIVE;
			xcmd_r <= 2'b00;
			srch_r <= 1'b0;
			abort_r <= 1'b0;
			dir_r <= 1'b0;
			mflush_r <= 1'b0;
			sig_flush_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sub_r <= sub_nxt;
			act_r <= act_nxt;
			xcmd_r <= xcmd_nxt;
			srch_r <= srch_nxt;
			abort_r <= abort_nxt;
			dir_r <= dir_nxt;
			mflush_r <= mflush_nxt;
			sig_flush_r <= sig_flush_nxt;
		end
	end

	// ---------------------------------------------
	// read data
	// ---------------------------------------------
	logic [7:0] status;
	always_comb begin
		status = 8'h00;
		status[MSTC_STAT_BUSY] = memory_op_busy_in;
		status[MSTC_STAT_TIMER] = run_r;
		status[MSTC_STAT_LOCK] = lock_sync_r[1] && operation_mode_bit0;
		status[MSTC_STAT_XACT] = state_r == MSTC_XFER;
		status[MSTC_STAT_ABORT] = abort_r;
		status[MSTC_STAT_ACC] = state_r != MSTC_XFER;
		status[MSTC_STAT_DIR] = dir_r;
		status[MSTC_STAT_EMPTY] = mon_level == 5'h00;
		unique case (reg_addr)
			MSTC_ADDR_ACTIVE: reg_rdata = {1'b0, srch_r, act_r[5:0]};
			MSTC_ADDR_MFIFO: reg_rdata = mon_out_data;
			MSTC_ADDR_SIGTIM: reg_rdata = {sig_ovalid, sig_ovalid ? sig_odata : 7'h00};
			MSTC_ADDR_STATCMD: reg_rdata = status;
			default: reg_rdata = 8'h00;
		endcase
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	sequence go_seq;
		cmd[MSTC_CMD_GO] && !wr_tim && operation_mode_bit0;
	endsequence
	timer_start_a: assert property (@(posedge core_clk) disable iff (!rstn)
		go_seq |=> run_r) else $error("timer did not start");
	timer_stop_a: assert property (@(posedge core_clk) disable iff (!rstn)
		wr_tim |=> !run_r) else $error("timer write did not stop timer");
	timer_mute_a: assert property (@(posedge core_clk) disable iff (!rstn)
		timer_event |-> $past(irqen_r)) else $error("timer event while muted");
	sig_flush_a: assert property (@(posedge core_clk) disable iff (!rstn)
		cmd[MSTC_CMD_SFLUSH] |-> ##2 !sig_ovalid) else $error("signaling flush late");
	mon_flush_a: assert property (@(posedge core_clk) disable iff (!rstn)
		cmd[MSTC_CMD_MFLUSH] |-> ##2 (mon_level == 5'h00 && !dir_r))
		else $error("monitor flush late");
	search_flag_a: assert property (@(posedge core_clk) disable iff (!rstn)
		srch_r == (state_r == MSTC_SEARCH)) else $error("search flag wrong");
	search_stop_a: assert property (@(posedge core_clk) disable iff (!rstn)
		state_r == MSTC_SEARCH && !hs_sync_r[1] |=> !srch_r && act_r[5:0] == $past(scan_slot))
		else $error("search did not store address");
	lock_flag_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!operation_mode_bit0 |-> !status[MSTC_STAT_LOCK]) else $error("lock with mode off");
	full_slot_a: assert property (@(posedge core_clk) disable iff (!rstn)
		slot_bandwidth_code == MSTC_BW_FULL |-> slot_bits_out == slot_byte_in)
		else $error("full slot mismatch");
	sig_odd_a: assert property (@(posedge core_clk) disable iff (!rstn)
		sig_change_valid && sig_change_is_line |-> sig_addr[0]) else $error("line entry even");
endmodule : mstc_ctrl
`default_nettype wire

// ---- sim/mstc_line_model.sv ----
// Purpose: line-side stand-in for the monitor channel and its subscriber circuit
// Assumes: a byte leaves when mon_tx_valid and mon_line_ready meet at a rising edge
// Notes: hold refuses bytes; slow takes at most one byte in four cycles
`timescale 1ns/100ps
`default_nettype none
module mstc_line_model (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic mon_tx_valid,
	input wire logic [7:0] mon_tx_byte,
	output logic mon_line_ready,
	output logic mon_rx_valid,
	output logic [7:0] mon_rx_byte,
	output logic mon_xfer_done,
	output logic mon_remote_abort
);
	logic [7:0] got [$];
	bit hold;
	bit slow;
	logic [1:0] pace_r;

	initial begin
		hold = 1'b0;
		slow = 1'b0;
		mon_rx_valid = 1'b0;
		mon_rx_byte = 8'h00;
		mon_xfer_done = 1'b0;
		mon_remote_abort = 1'b0;
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pace_r <= 2'h0;
			mon_line_ready <= 1'b0;
		end else begin
			if (mon_tx_valid === 1'b1 && mon_line_ready === 1'b1) begin
				got.push_back(mon_tx_byte);
			end
			pace_r <= pace_r + 2'h1;
			mon_line_ready <= !hold && (!slow || pace_r == 2'h0);
		end
	end

	// 0 receive byte, 1 transfer done, 2 remote abort; one cycle each
	task automatic pulse(input int which, input logic [7:0] b);
		@(posedge core_clk);
		#1;
		mon_rx_byte = b;
		mon_rx_valid = (which == 0);
		mon_xfer_done = (which == 1);
		mon_remote_abort = (which == 2);
		@(posedge core_clk);
		#1;
		mon_rx_valid = 1'b0;
		mon_xfer_done = 1'b0;
		mon_remote_abort = 1'b0;
		// released data must not look like a held byte
		mon_rx_byte = ~b;
	endtask : pulse
endmodule : mstc_line_model
`default_nettype wire

// ---- sim/tb_monitor_signaling_timer_ctrl.sv ----
// Purpose: self-checking bench for the monitor, signaling and timer register bank
// Assumes: strobes driven 1 ns after the rising edge; read data sampled 1 ns before the next rising edge
// Notes: timer prescale is not shortened, so one timer period dominates run time
`timescale 1ns/100ps
`default_nettype none
module tb_monitor_signaling_timer_ctrl
	import mstc_pkg::*;
;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic operation_mode_bit0 = 1'b1;
	logic handshake_protocol_select = 1'b1;
	logic memory_op_busy_in = 1'b0;
	logic frame_match_in = 1'b0;
	logic [2:0] slot_bandwidth_code = 3'h1;
	logic [7:0] slot_byte_in = 8'h00;
	logic [7:0] slot_bits_out;
	logic slot_code_illegal;
	logic sig_change_valid = 1'b0;
	logic [6:0] sig_change_slot = 7'h00;
	logic sig_change_is_line = 1'b0;
	logic [5:0] scan_slot = 6'h2a;
	logic monitor_handover_bit = 1'b1;
	logic mon_line_ready, mon_tx_valid, mon_xfer_hs, mon_rx_valid, mon_xfer_done;
	logic mon_remote_abort, timer_event, last_look_tick;
	logic [7:0] mon_tx_byte, mon_subscriber, mon_rx_byte;
	logic [1:0] mon_xfer_cmd;
	logic [7:0] d;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;
	int looks = 0;
	// code, input byte, expected bits, expected illegal flag
	localparam logic [19:0] ROWS [8] = '{
		{3'h0, 8'h9c, 8'h00, 1'b1}, {3'h1, 8'h9c, 8'h9c, 1'b0}, {3'h2, 8'h9c, 8'h0c, 1'b0},
		{3'h3, 8'h9c, 8'h09, 1'b0}, {3'h4, 8'h9e, 8'h02, 1'b0}, {3'h5, 8'h9c, 8'h03, 1'b0},
		{3'h6, 8'h9c, 8'h01, 1'b0}, {3'h7, 8'h9c, 8'h02, 1'b0}};

	always #2 core_clk = ~core_clk;

	mstc_ctrl uut (.core_clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.operation_mode_bit0, .handshake_protocol_select, .memory_op_busy_in, .frame_match_in,
		.slot_bandwidth_code, .slot_byte_in, .slot_bits_out, .slot_code_illegal,
		.sig_change_valid, .sig_change_slot, .sig_change_is_line, .scan_slot,
		.monitor_handover_bit, .mon_line_ready, .mon_tx_valid, .mon_tx_byte, .mon_subscriber,
		.mon_xfer_cmd, .mon_xfer_hs, .mon_rx_valid, .mon_rx_byte, .mon_xfer_done,
		.mon_remote_abort, .timer_event, .last_look_tick);

	mstc_line_model partner (.core_clk, .rstn, .mon_tx_valid, .mon_tx_byte, .mon_line_ready,
		.mon_rx_valid, .mon_rx_byte, .mon_xfer_done, .mon_remote_abort);

	// ----------------------------------------
	// reporting and bus tasks
	// ----------------------------------------
	task automatic wrap_up();
		if (fails == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	// a hung handshake ends the run here
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (last_look_tick === 1'b1) looks <= looks + 1;
		if (cycles == 90000) begin
			fails = fails + 1;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		tests_run++;
		if (got < lo || got > hi) begin
			fails++;
			$display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : chk_rng

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		#2;
		v = reg_rdata;
		@(posedge core_clk);
		#1;
		reg_rd = 1'b0;
	endtask : rd

	task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] m,
		input logic [7:0] e);
		rd(a, d);
		chk(what, e, d & m);
	endtask : rchk

	task automatic sig(input logic [6:0] slot, input logic line);
		@(posedge core_clk);
		#1;
		sig_change_slot = slot;
		sig_change_is_line = line;
		sig_change_valid = 1'b1;
		@(posedge core_clk);
		#1;
		sig_change_valid = 1'b0;
	endtask : sig

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int k;
		repeat (16) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		rchk("status_reset", MSTC_ADDR_STATCMD, 8'hff, 8'h05);
		rchk("status_reread", MSTC_ADDR_STATCMD, 8'hff, 8'h05);
		rchk("active_reset", MSTC_ADDR_ACTIVE, 8'hff, 8'h00);
		wr(MSTC_ADDR_STATCMD, 8'h80);
		rchk("cmd_top_bit", MSTC_ADDR_STATCMD, 8'hff, 8'h05);
		foreach (ROWS[i]) begin
			@(posedge core_clk);
			#1;
			slot_bandwidth_code = ROWS[i][19:17];
			slot_byte_in = ROWS[i][16:9];
			#1;
			chk("slot_illegal", {7'h00, ROWS[i][0]}, {7'h00, slot_code_illegal});
			if (ROWS[i][0] == 1'b0) chk("slot_bits", ROWS[i][8:1], slot_bits_out);
		end
		@(posedge core_clk);
		#1;
		frame_match_in = 1'b1;
		repeat (4) @(posedge core_clk);
		rchk("lock_on", MSTC_ADDR_STATCMD, 8'h20, 8'h20);
		operation_mode_bit0 = 1'b0;
		rchk("lock_mode_off", MSTC_ADDR_STATCMD, 8'h20, 8'h00);
		operation_mode_bit0 = 1'b1;
		memory_op_busy_in = 1'b1;
		rchk("busy_on", MSTC_ADDR_STATCMD, 8'h80, 8'h80);
		memory_op_busy_in = 1'b0;
		rchk("busy_off", MSTC_ADDR_STATCMD, 8'h80, 8'h00);
		// ten changes into nine places: the last one is dropped
		for (int i = 0; i < 10; i++) sig(7'(i * 12), i[0]);
		for (int i = 0; i < 10; i++) begin
			rchk("sig_entry", MSTC_ADDR_SIGTIM, (i < 9) ? 8'hff : 8'h80,
				(i < 9) ? {1'b1, (7'(i * 12) | {6'h00, i[0]})} : 8'h00);
		end
		sig(7'h20, 1'b0);
		sig(7'h30, 1'b1);
		wr(MSTC_ADDR_STATCMD, 8'h10);
		rchk("sig_flushed", MSTC_ADDR_SIGTIM, 8'h80, 8'h00);
		// full transmit with a slow line, one byte too many offered
		wr(MSTC_ADDR_ACTIVE, 8'h05);
		for (int i = 0; i < 16; i++) wr(MSTC_ADDR_MFIFO, 8'h10 + 8'(i));
		wr(MSTC_ADDR_MFIFO, 8'hee);
		rchk("mfifo_filled", MSTC_ADDR_STATCMD, 8'h01, 8'h00);
		partner.slow = 1'b1;
		wr(MSTC_ADDR_STATCMD, 8'h04);
		chk("sub_addr", 8'h05, mon_subscriber);
		chk("xfer_cmd", 8'h01, {6'h00, mon_xfer_cmd});
		chk("xfer_hs", 8'h01, {7'h00, mon_xfer_hs});
		rchk("xfer_on", MSTC_ADDR_STATCMD, 8'h10, 8'h10);
		for (k = 0; k < 400 && partner.got.size() < 16; k++) @(posedge core_clk);
		repeat (20) @(posedge core_clk);
		chk_rng("tx_count", 16, 16, partner.got.size());
		foreach (partner.got[i]) chk("tx_byte", 8'h10 + 8'(i), partner.got[i]);
		partner.pulse(1, 8'h00);
		rchk("xfer_end", MSTC_ADDR_STATCMD, 8'h11, 8'h01);
		// stalled transfer aborted by the far end, then a search survives a flush
		partner.slow = 1'b0;
		partner.hold = 1'b1;
		wr(MSTC_ADDR_MFIFO, 8'h33);
		wr(MSTC_ADDR_MFIFO, 8'h44);
		wr(MSTC_ADDR_STATCMD, 8'h04);
		partner.pulse(2, 8'h00);
		rchk("aborted", MSTC_ADDR_STATCMD, 8'h18, 8'h08);
		wr(MSTC_ADDR_STATCMD, 8'h02);
		rchk("search_on", MSTC_ADDR_ACTIVE, 8'hc0, 8'h40);
		wr(MSTC_ADDR_STATCMD, 8'h01);
		rchk("mon_flushed", MSTC_ADDR_STATCMD, 8'h07, 8'h05);
		rchk("search_kept", MSTC_ADDR_ACTIVE, 8'hc0, 8'h40);
		monitor_handover_bit = 1'b0;
		d = 8'hff;
		for (k = 0; k < 50 && d[6] !== 1'b0; k++) rd(MSTC_ADDR_ACTIVE, d);
		chk("found_addr", 8'h2a, d);
		monitor_handover_bit = 1'b1;
		// receive one byte after an empty transmit
		partner.hold = 1'b0;
		wr(MSTC_ADDR_STATCMD, 8'h08);
		partner.pulse(0, 8'h5a);
		partner.pulse(1, 8'h00);
		rchk("rx_dir", MSTC_ADDR_STATCMD, 8'h03, 8'h02);
		rchk("rx_byte", MSTC_ADDR_MFIFO, 8'hff, 8'h5a);
		rchk("rx_drained", MSTC_ADDR_STATCMD, 8'h03, 8'h01);
		// one timer period at reload 0 with the fixed last-look rate
		wr(MSTC_ADDR_SIGTIM, 8'h80);
		wr(MSTC_ADDR_STATCMD, 8'h60);
		looks = 0;
		rchk("timer_on", MSTC_ADDR_STATCMD, 8'h40, 8'h40);
		for (k = 0; k < 70000 && timer_event !== 1'b1; k++) begin
			@(posedge core_clk);
			#1;
		end
		chk_rng("timer_period", MSTC_TICK_CYC - 10, MSTC_TICK_CYC + 5, k);
		chk_rng("look_ticks", 1, 2, looks);
		wr(MSTC_ADDR_SIGTIM, 8'h00);
		rchk("timer_stop", MSTC_ADDR_STATCMD, 8'h40, 8'h00);
		wr(MSTC_ADDR_STATCMD, 8'h40);
		rchk("timer_restart", MSTC_ADDR_STATCMD, 8'h40, 8'h40);
		operation_mode_bit0 = 1'b0;
		rchk("timer_mode_off", MSTC_ADDR_STATCMD, 8'h40, 8'h00);
		// reset in mid-run with the timer running and a stored search result
		operation_mode_bit0 = 1'b1;
		wr(MSTC_ADDR_STATCMD, 8'h40);
		rstn = 1'b0;
		@(posedge core_clk);
		#1;
		rstn = 1'b1;
		rchk("status_rerst", MSTC_ADDR_STATCMD, 8'hdf, 8'h05);
		rchk("active_rerst", MSTC_ADDR_ACTIVE, 8'hff, 8'h00);
		wrap_up();
	end
endmodule : tb_monitor_signaling_timer_ctrl
`default_nettype wire
